// file: common/omsc_pkg.sv
// Constants, types and register layout for the operating mode and system control bank.
// Assumes a 32-bit APB slave port and a single 10 MHz core clock.
`default_nettype none
package omsc_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [31:0] RB_INDEX = 32'h000ee011;
	localparam logic [31:0] SC_INDEX = 32'h000ee012;
	localparam logic [31:0] RB_ADDR = {RB_INDEX[29:0], 2'b00};
	localparam logic [31:0] SC_ADDR = {SC_INDEX[29:0], 2'b00};

	// Readback fixed bits: 7..6 read one, 5..3 read zero.
	localparam logic [7:0] RB_FIXED = 8'hc0;
	localparam int RB_STRAP_MSB = 2;

	// System control field positions and reset value.
	localparam int SC_STANDBY_SEL_BIT = 7;
	localparam int SC_SETTLE_LSB = 4;
	localparam int SC_USER_EN_BIT = 3;
	localparam int SC_NMI_EDGE_BIT = 2;
	localparam int SC_STANDBY_OE_BIT = 1;
	localparam int SC_RAM_EN_BIT = 0;
	localparam logic [7:0] SC_RESET = 8'h09;

	// Oscillator settle waits in system clock states, one per field code 0 to 6.
	localparam int SETTLE_STATES_0 = 8192;
	localparam int SETTLE_STATES_1 = 16384;
	localparam int SETTLE_STATES_2 = 32768;
	localparam int SETTLE_STATES_3 = 65536;
	localparam int SETTLE_STATES_4 = 131072;
	localparam int SETTLE_STATES_5 = 262144;
	localparam int SETTLE_STATES_6 = 1024;
	localparam int SETTLE_CNT_W = 19;

	// Strap codes.
	localparam logic [2:0] MODE_PROHIBITED = 3'h0;
	localparam logic [2:0] MODE_LAST_EXPANDED = 3'h5;

	typedef enum logic [1:0] {
		OMSC_SPACE_NONE,
		OMSC_SPACE_64K,
		OMSC_SPACE_1M,
		OMSC_SPACE_16M
	} omsc_space_t;

	typedef struct packed {
		logic standby_select;
		logic [2:0] settle_time;
		logic user_flag_enable;
		logic nonmaskable_edge_select;
		logic standby_output_enable;
		logic internal_ram_enable;
	} omsc_sysctl_t;

	typedef struct packed {
		logic valid;
		logic expanded;
		logic rom_en;
		logic bus16_init;
		omsc_space_t space;
	} omsc_mode_info_t;
endpackage : omsc_pkg
`default_nettype wire

// file: hw/omsc_top.sv
// Operating mode decoder, mode readback and system control register bank.
// Assumes straps arrive asynchronously from the board, CPU events arrive on core_clk.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module omsc_top #(
	parameter int SETTLE_0 = omsc_pkg::SETTLE_STATES_0,
	parameter int SETTLE_1 = omsc_pkg::SETTLE_STATES_1,
	parameter int SETTLE_2 = omsc_pkg::SETTLE_STATES_2,
	parameter int SETTLE_3 = omsc_pkg::SETTLE_STATES_3,
	parameter int SETTLE_4 = omsc_pkg::SETTLE_STATES_4,
	parameter int SETTLE_5 = omsc_pkg::SETTLE_STATES_5,
	parameter int SETTLE_6 = omsc_pkg::SETTLE_STATES_6
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Board straps and NMI pin
	input wire logic mode_strap_high,
	input wire logic mode_strap_middle,
	input wire logic mode_strap_low,
	input wire logic flash_boot_strap,
	input wire logic nmi_pin,
	// CPU and bus controller events
	input wire logic sleep_exec,
	input wire logic ext_irq_wake,
	input wire logic exception_entry,
	input wire logic [7:0] area_width_8bit,
	input wire logic ram_range_access,
	// Mode results
	output logic [2:0] mode_number,
	output logic mode_prohibited,
	output omsc_pkg::omsc_space_t addr_space,
	output logic ext_access_en,
	output logic rom_en,
	output logic initial_bus_16,
	output logic bus_16bit_mode,
	output logic ram_enable,
	output logic ram_route_external,
	// Power and interrupt control
	output logic sleep_active,
	output logic standby_active,
	output logic cpu_hold,
	output logic nmi_request,
	output logic set_int_mask,
	output logic set_user_flag,
	output logic user_flag_is_user_bit,
	// Bus pin control
	output logic addr_bus_oe,
	output logic strobe_oe,
	output logic strobe_force_high
);
	typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_STANDBY, ST_SETTLE} omsc_pwr_t;

	// Strap and pin synchronisers: three stages, a change counts when stages two and three agree.
	localparam int NSYNC = 5;
	wire logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] s1_reg;
	logic [NSYNC-1:0] s2_reg;
	logic [NSYNC-1:0] s3_reg;
	logic [NSYNC-1:0] pin_q_reg;
	assign pin_raw = {nmi_pin, flash_boot_strap, mode_strap_high, mode_strap_middle,
		mode_strap_low};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					s1_reg[gi] <= 1'b0;
					s2_reg[gi] <= 1'b0;
					s3_reg[gi] <= 1'b0;
					pin_q_reg[gi] <= 1'b0;
				end else begin
					s1_reg[gi] <= pin_raw[gi];
					s2_reg[gi] <= s1_reg[gi];
					s3_reg[gi] <= s2_reg[gi];
					if (s2_reg[gi] == s3_reg[gi]) begin
						pin_q_reg[gi] <= s3_reg[gi];
					end
				end
			end
		end
	endgenerate

	wire logic [2:0] strap_code;
	wire logic boot_q;
	wire logic nmi_q;
	assign strap_code = pin_q_reg[2:0];
	assign boot_q = pin_q_reg[3];
	assign nmi_q = pin_q_reg[4];

	// Mode decode. The board must hold the straps steady outside reset, so decoding
	// them continuously is the same as latching them once.
	omsc_pkg::omsc_mode_info_t info;
	always_comb begin
		info = '{valid: 1'b1, expanded: 1'b1, rom_en: 1'b0, bus16_init: 1'b0,
			space: omsc_pkg::OMSC_SPACE_1M};
		case (strap_code)
			3'h1: info.bus16_init = 1'b0;
			3'h2: info.bus16_init = 1'b1;
			3'h3: info.space = omsc_pkg::OMSC_SPACE_16M;
			3'h4: begin
				info.bus16_init = 1'b1;
				info.space = omsc_pkg::OMSC_SPACE_16M;
			end
			3'h5: begin
				info.rom_en = 1'b1;
				info.space = omsc_pkg::OMSC_SPACE_16M;
			end
			3'h6: begin
				info.expanded = 1'b0;
				info.rom_en = 1'b1;
				info.space = omsc_pkg::OMSC_SPACE_64K;
			end
			3'h7: begin
				info.expanded = 1'b0;
				info.rom_en = 1'b1;
			end
			default: begin
				// A prohibited code enables nothing rather than guessing a mode.
				info = '{valid: 1'b0, expanded: 1'b0, rom_en: 1'b0, bus16_init: 1'b0,
					space: omsc_pkg::OMSC_SPACE_NONE};
			end
		endcase
	end

	// Control register and APB decode.
	omsc_pkg::omsc_sysctl_t sc_reg;
	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;

	wire logic hit_rb;
	wire logic hit_sc;
	wire logic access_phase;
	wire logic do_write_sc;
	wire logic [7:0] rb_value;
	wire logic [31:0] read_mux;
	assign hit_rb = (paddr == omsc_pkg::RB_ADDR);
	assign hit_sc = (paddr == omsc_pkg::SC_ADDR);
	assign access_phase = psel & penable & ~pready_reg;
	// Writes land only when pready is seen high; readback writes fall through unused.
	assign do_write_sc = psel & penable & pready_reg & pwrite & hit_sc & pstrb[0];
	assign rb_value = omsc_pkg::RB_FIXED
		| {5'h00, strap_code[omsc_pkg::RB_STRAP_MSB] ^ boot_q, strap_code[1:0]};
	assign read_mux = hit_rb ? {24'h000000, rb_value} :
		hit_sc ? {24'h000000, sc_reg} : 32'h00000000;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= access_phase;
			pslverr_reg <= access_phase & ~(hit_rb | hit_sc);
			if (access_phase && !pwrite) begin
				prdata_reg <= read_mux;
			end
		end
	end

	// Power state machine and oscillator settle counter.
	omsc_pwr_t pwr_reg;
	omsc_pwr_t pwr_next;
	logic [omsc_pkg::SETTLE_CNT_W-1:0] settle_cnt_reg;
	logic [omsc_pkg::SETTLE_CNT_W-1:0] settle_load;

	always_comb begin
		case (sc_reg.settle_time)
			3'h0: settle_load = omsc_pkg::SETTLE_CNT_W'(SETTLE_0);
			3'h1: settle_load = omsc_pkg::SETTLE_CNT_W'(SETTLE_1);
			3'h2: settle_load = omsc_pkg::SETTLE_CNT_W'(SETTLE_2);
			3'h3: settle_load = omsc_pkg::SETTLE_CNT_W'(SETTLE_3);
			3'h4: settle_load = omsc_pkg::SETTLE_CNT_W'(SETTLE_4);
			3'h6: settle_load = omsc_pkg::SETTLE_CNT_W'(SETTLE_6);
			// The illegal code waits the longest, which is the safe side for a crystal.
			default: settle_load = omsc_pkg::SETTLE_CNT_W'(SETTLE_5);
		endcase
	end

	always_comb begin
		pwr_next = pwr_reg;
		case (pwr_reg)
			ST_RUN: begin
				if (sleep_exec) begin
					pwr_next = sc_reg.standby_select ? ST_STANDBY : ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (ext_irq_wake) begin
					pwr_next = ST_RUN;
				end
			end
			ST_STANDBY: begin
				if (ext_irq_wake) begin
					pwr_next = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (settle_cnt_reg == 1) begin
					pwr_next = ST_RUN;
				end
			end
			default: pwr_next = ST_RUN;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pwr_reg <= ST_RUN;
			settle_cnt_reg <= '0;
		end else begin
			pwr_reg <= pwr_next;
			if (pwr_reg == ST_STANDBY) begin
				settle_cnt_reg <= settle_load;
			end else if (settle_cnt_reg != 0) begin
				settle_cnt_reg <= settle_cnt_reg - 1'b1;
			end
		end
	end

	// Control register: whole byte per write; standby entry and exit never touch it,
	// so the standby select and RAM enable bits survive.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sc_reg <= omsc_pkg::SC_RESET;
		end else if (do_write_sc) begin
			sc_reg <= pwdata[7:0];
		end
	end

	// Nonmaskable edge detect on the filtered pin level.
	logic nmi_prev_reg;
	wire logic nmi_edge;
	assign nmi_edge = sc_reg.nonmaskable_edge_select ? (nmi_q & ~nmi_prev_reg)
		: (~nmi_q & nmi_prev_reg);

	// Bus pin control: in standby the enable decides float or hold.
	wire logic in_standby;
	wire logic pins_driven;
	assign in_standby = (pwr_next == ST_STANDBY);
	assign pins_driven = info.expanded & (~in_standby | sc_reg.standby_output_enable);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			nmi_prev_reg <= 1'b0;
			mode_number <= 3'h0;
			mode_prohibited <= 1'b1;
			addr_space <= omsc_pkg::OMSC_SPACE_NONE;
			ext_access_en <= 1'b0;
			rom_en <= 1'b0;
			initial_bus_16 <= 1'b0;
			bus_16bit_mode <= 1'b0;
			ram_enable <= 1'b1;
			ram_route_external <= 1'b0;
			sleep_active <= 1'b0;
			standby_active <= 1'b0;
			cpu_hold <= 1'b0;
			nmi_request <= 1'b0;
			set_int_mask <= 1'b0;
			set_user_flag <= 1'b0;
			user_flag_is_user_bit <= 1'b1;
			addr_bus_oe <= 1'b0;
			strobe_oe <= 1'b0;
			strobe_force_high <= 1'b0;
		end else begin
			nmi_prev_reg <= nmi_q;
			mode_number <= info.valid ? strap_code : omsc_pkg::MODE_PROHIBITED;
			mode_prohibited <= ~info.valid;
			addr_space <= info.space;
			ext_access_en <= info.expanded;
			rom_en <= info.rom_en;
			initial_bus_16 <= info.bus16_init;
			bus_16bit_mode <= info.expanded & ~(&area_width_8bit);
			ram_enable <= sc_reg.internal_ram_enable;
			ram_route_external <= info.expanded & ~sc_reg.internal_ram_enable
				& ram_range_access;
			sleep_active <= (pwr_next == ST_SLEEP);
			standby_active <= in_standby;
			cpu_hold <= (pwr_next == ST_STANDBY) | (pwr_next == ST_SETTLE);
			nmi_request <= nmi_edge;
			set_int_mask <= exception_entry;
			set_user_flag <= exception_entry & ~sc_reg.user_flag_enable;
			user_flag_is_user_bit <= sc_reg.user_flag_enable;
			addr_bus_oe <= pins_driven;
			strobe_oe <= pins_driven;
			strobe_force_high <= info.expanded & in_standby & sc_reg.standby_output_enable;
		end
	end

	assign pready = pready_reg;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;

	// Checks.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	property p_rb_fixed;
		pready && hit_rb && !pwrite |-> prdata[7:3] == 5'h18;
	endproperty
	a_rb_fixed: assert property (p_rb_fixed) else $error("readback fixed bits wrong");

	property p_rb_hi_zero;
		pready && !pwrite |-> prdata[31:8] == 24'h000000;
	endproperty
	a_rb_hi_zero: assert property (p_rb_hi_zero) else $error("upper read bits not zero");

	property p_sc_write;
		do_write_sc |=> sc_reg == $past(pwdata[7:0]);
	endproperty
	a_sc_write: assert property (p_sc_write) else $error("control write lost");

	property p_sleep_sel;
		pwr_reg == ST_RUN && sleep_exec
			|=> (sc_reg.standby_select ? $past(sc_reg.standby_select) : 1'b1)
			&& (pwr_reg == ($past(sc_reg.standby_select) ? ST_STANDBY : ST_SLEEP));
	endproperty
	a_sleep_sel: assert property (p_sleep_sel) else $error("wrong low power entry");

	property p_select_kept;
		pwr_reg == ST_SETTLE && pwr_next == ST_RUN
			|=> sc_reg.standby_select || $past(do_write_sc);
	endproperty
	a_select_kept: assert property (p_select_kept) else $error("standby select cleared by exit");

	property p_hold_settle;
		pwr_reg == ST_STANDBY && ext_irq_wake |=> cpu_hold [*3];
	endproperty
	a_hold_settle: assert property (p_hold_settle) else $error("cpu not held while settling");

	property p_user_flag;
		exception_entry |=> set_int_mask && (set_user_flag == !$past(sc_reg.user_flag_enable));
	endproperty
	a_user_flag: assert property (p_user_flag) else $error("exception flag set wrong");

	property p_bus_width;
		ext_access_en && (&$past(area_width_8bit)) |-> !bus_16bit_mode;
	endproperty
	a_bus_width: assert property (p_bus_width) else $error("16-bit bus with all areas 8-bit");

	property p_route;
		ram_route_external |-> ext_access_en && !ram_enable;
	endproperty
	a_route: assert property (p_route) else $error("RAM routed external while enabled");

	property p_float;
		standby_active && !$past(sc_reg.standby_output_enable) |-> !addr_bus_oe && !strobe_oe;
	endproperty
	a_float: assert property (p_float) else $error("pins driven in standby");

	property p_mode7;
		strap_code == 3'h7 |=> rom_en && !ext_access_en && addr_space == omsc_pkg::OMSC_SPACE_1M;
	endproperty
	a_mode7: assert property (p_mode7) else $error("single-chip large mode decode wrong");
endmodule : omsc_top
`default_nettype wire

// file: tb/omsc_board_model.sv
// Board model: drives the three mode straps and the boot strap.
// Assumes the bench requests a strap setting and holds reset around any change.
`timescale 1ns/1ps
`default_nettype none
module omsc_board_model (
	// Requests from the bench
	input wire logic arst_n,
	input wire logic [2:0] mode_req,
	input wire logic boot_req,
	// Strap levels
	output logic [2:0] straps,
	output logic boot
);
	// Straps follow a request only while reset is held, so they never move in operation.
	always_latch begin
		if (!arst_n) begin
			straps <= mode_req;
			boot <= boot_req;
		end
	end
endmodule : omsc_board_model
`default_nettype wire

// file: tb/operating_mode_system_control_tb_top.sv
// Self-checking bench for the mode decoder and system control bank.
// Assumes the board model drives the straps and the bench acts as APB master and CPU.
`timescale 1ns/1ps
`default_nettype none
module operating_mode_system_control_tb_top;
	localparam int BASE = 8;
	logic core_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, boot_req = 0, boot;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic nmi_pin = 0, sleep_exec = 0, ext_irq_wake = 0, exception_entry = 0;
	logic ram_range_access = 0, err, pready, pslverr, mode_prohibited, ext_access_en, rom_en;
	logic [7:0] area_width_8bit = 8'hff;
	logic [2:0] mode_req = 3'h1, straps, mode_number;
	logic initial_bus_16, bus_16bit_mode, ram_enable, ram_route_external, sleep_active;
	logic standby_active, cpu_hold, nmi_request, set_int_mask, set_user_flag;
	logic user_flag_is_user_bit, addr_bus_oe, strobe_oe, strobe_force_high;
	omsc_pkg::omsc_space_t addr_space;
	int error_cnt = 0, samples_checked = 0, cyc = 0, n, ctl;

	// Settle counts are shrunk for simulation; on silicon software keeps the wait at
	// least 7 ms, which the bench cannot show at these counts.
	omsc_top #(.SETTLE_0(BASE), .SETTLE_1(BASE + 1), .SETTLE_2(BASE + 2), .SETTLE_3(BASE + 3),
		.SETTLE_4(BASE + 4), .SETTLE_5(BASE + 5), .SETTLE_6(BASE + 6)) dut (.core_clk, .arst_n,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
		.mode_strap_high(straps[2]), .mode_strap_middle(straps[1]), .mode_strap_low(straps[0]),
		.flash_boot_strap(boot), .nmi_pin, .sleep_exec, .ext_irq_wake, .exception_entry,
		.area_width_8bit, .ram_range_access, .mode_number, .mode_prohibited, .addr_space,
		.ext_access_en, .rom_en, .initial_bus_16, .bus_16bit_mode, .ram_enable,
		.ram_route_external, .sleep_active, .standby_active, .cpu_hold, .nmi_request,
		.set_int_mask, .set_user_flag, .user_flag_is_user_bit, .addr_bus_oe, .strobe_oe,
		.strobe_force_high);

	omsc_board_model board (.arst_n, .mode_req, .boot_req, .straps, .boot);

	always #50 core_clk = ~core_clk;

	// The whole run needs well under a thousand cycles; the ceiling leaves ample margin.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic do_reset(input logic [2:0] m, input logic b);
		arst_n <= 0;
		mode_req <= m;
		boot_req <= b;
		repeat (5) @(posedge core_clk);
		arst_n <= 1;
		repeat (6) @(posedge core_clk);
	endtask : do_reset

	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	// One-cycle strobe on {sleep_exec, ext_irq_wake, exception_entry}.
	task automatic pulse(input logic [2:0] which);
		{sleep_exec, ext_irq_wake, exception_entry} <= which;
		@(posedge core_clk);
		{sleep_exec, ext_irq_wake, exception_entry} <= 3'b000;
		@(posedge core_clk);
	endtask : pulse

	function automatic logic [31:0] mode_exp(input int m);
		int sp;
		sp = (m == 0) ? 0 : (m == 6) ? 1 : (m >= 3 && m <= 5) ? 3 : 2;
		return {m == 0, m[2:0], sp[1:0], m >= 1 && m <= 5, m >= 5, m == 2 || m == 4};
	endfunction : mode_exp

	initial begin
		void'($urandom(23967));
		for (int m = 0; m < 8; m++) begin
			logic ex;
			ex = m >= 1 && m <= 5;
			do_reset(m[2:0], m == 7);
			chk("mode outputs", mode_exp(m), {mode_prohibited, mode_number, addr_space,
				ext_access_en, rom_en, initial_bus_16});
			apb(0, omsc_pkg::SC_ADDR, 0);
			chk("control reset", 32'h09, rd);
			apb(1, omsc_pkg::RB_ADDR, 32'hff);
			apb(0, omsc_pkg::RB_ADDR, 0);
			chk("readback", 32'hc0 | (m ^ ((m == 7) << 2)), rd);
			ctl = $urandom & 'hff;
			if (ctl[6:4] == 7)
				ctl[6] = 0;
			area_width_8bit <= m[0] ? 8'hff : 8'($urandom);
			ram_range_access <= 1'($urandom);
			apb(1, omsc_pkg::SC_ADDR, ctl);
			apb(0, omsc_pkg::SC_ADDR, 0);
			chk("control", ctl, rd);
			chk("control levels", {ctl[0], ctl[3], ex && !ctl[0] && ram_range_access,
				ex && area_width_8bit != 8'hff}, {ram_enable, user_flag_is_user_bit,
				ram_route_external, bus_16bit_mode});
			pulse(3'b001);
			chk("exception flags", {1'b1, !ctl[3]}, {set_int_mask, set_user_flag});
			repeat (2) begin
				nmi_pin <= !nmi_pin;
				n = 0;
				repeat (10) begin
					@(posedge core_clk);
					n += (nmi_request === 1'b1);
				end
				chk("nmi pulses", nmi_pin == ctl[2], n);
			end
			$display("mode %0d test done", m);
		end
		do_reset(3'h1, 0);
		for (int c = 0; c < 7; c++) begin
			ctl = 'h81 | (c << 4) | ((c & 1) << 1);
			apb(1, omsc_pkg::SC_ADDR, ctl);
			pulse(3'b100);
			chk("standby entry", {3'b011, ctl[1], ctl[1], ctl[1]}, {sleep_active, standby_active,
				cpu_hold, addr_bus_oe, strobe_oe, strobe_force_high});
			ext_irq_wake <= 1;
			@(posedge core_clk);
			ext_irq_wake <= 0;
			n = 0;
			while (cpu_hold === 1'b1 && n < 100) begin
				@(posedge core_clk);
				n++;
			end
			// N settle states, plus one edge for the registered wake and hold outputs.
			chk("settle wait", BASE + c + 1, n);
			chk("standby exit", 5'b00110, {standby_active, cpu_hold, addr_bus_oe, strobe_oe,
				strobe_force_high});
			apb(0, omsc_pkg::SC_ADDR, 0);
			chk("control after standby", ctl, rd);
		end
		$display("standby test done");
		apb(1, omsc_pkg::SC_ADDR, 32'h09);
		pulse(3'b100);
		chk("sleep entry", 2'b10, {sleep_active, standby_active});
		pulse(3'b010);
		@(posedge core_clk);
		chk("sleep exit", 0, sleep_active);
		pstrb <= 4'h0;
		apb(1, omsc_pkg::SC_ADDR, 32'hff);
		pstrb <= 4'hf;
		apb(0, omsc_pkg::SC_ADDR, 0);
		chk("control strobe off", 32'h09, rd);
		apb(0, 32'h0, 0);
		chk("unmapped error", 1, err);
		chk("unmapped data", 0, rd);
		$display("sleep and bus test done");
		stop_test();
	end
endmodule : operating_mode_system_control_tb_top
`default_nettype wire
